/* rtl/lcd_pkg.sv */
// Purpose: Shared constants and types for the laser current DAC control block.
// Assumes: Register addresses are 5-bit word addresses of the three-wire port.
// Notes: Serial framing itself lives outside this block.
package lcd_pkg;
   // Register addresses.
   localparam logic [4:0] LCD_ADDR_CTRL = 5'h05;
   localparam logic [4:0] LCD_ADDR_STAT1 = 5'h06;
   localparam logic [4:0] LCD_ADDR_STAT2 = 5'h07;
   localparam logic [4:0] LCD_ADDR_BIAS_CODE = 5'h08;
   localparam logic [4:0] LCD_ADDR_MOD_CODE = 5'h09;
   localparam logic [4:0] LCD_ADDR_MOD_LIMIT = 5'h0A;
   localparam logic [4:0] LCD_ADDR_BIAS_LIMIT = 5'h0B;
   localparam logic [4:0] LCD_ADDR_MOD_STEP = 5'h0C;
   localparam logic [4:0] LCD_ADDR_BIAS_STEP = 5'h0D;
   localparam logic [4:0] LCD_ADDR_MODE = 5'h0E;
   localparam logic [4:0] LCD_ADDR_PW = 5'h0F;
   localparam logic [4:0] LCD_ADDR_DEEMPH = 5'h10;
   localparam logic [4:0] LCD_ADDR_EQ = 5'h11;
   // Setup-mode unlock value.
   localparam logic [7:0] LCD_SETUP_KEY = 8'h12;
   // Control register fields and reset value.
   localparam int LCD_CTRL_EN = 0;
   localparam int LCD_CTRL_POL = 1;
   localparam int LCD_CTRL_SOFTRES = 2;
   localparam int LCD_CTRL_EQ_EN = 3;
   localparam int LCD_CTRL_DE_LO = 4;
   localparam int LCD_CTRL_DE_HI = 5;
   localparam logic [7:0] LCD_CTRL_RST = 8'h03;
   localparam logic [7:0] LCD_ZERO_RST = 8'h00;
   // Status register 1 fields.
   localparam int LCD_ST1_FAULT = 0;
   localparam int LCD_ST1_BIAS_LOW = 1;
   localparam int LCD_ST1_OUT_LOW = 2;
   localparam int LCD_ST1_OUT_CM = 3;
   localparam int LCD_ST1_BIAS_LIMIT_SENSE = 4;
   localparam int LCD_ST1_BIAS_MONITOR_OUT = 6;
   localparam int LCD_ST1_POR = 7;
   // Status register 2 fields.
   localparam int LCD_ST2_NO_AC = 1;
   localparam int LCD_ST2_BIAS_ERR = 2;
   localparam int LCD_ST2_MOD_ERR = 3;
   // Step field width and deemphasis mode codes.
   localparam int LCD_STEP_W = 5;
   typedef enum logic [1:0] {
      LCD_DE_FIX_6P25 = 2'b00,
      LCD_DE_FIX_3P125 = 2'b01,
      LCD_DE_PROG = 2'b10,
      LCD_DE_MAX = 2'b11
   } lcd_de_mode_t;
   // Deemphasis level in 6-bit units of the analog stage (approximate fractions of 64).
   localparam logic [5:0] LCD_DE_LVL_6P25 = 6'h04;
   localparam logic [5:0] LCD_DE_LVL_3P125 = 6'h02;
   localparam logic [5:0] LCD_DE_LVL_MAX = 6'h06;
endpackage : lcd_pkg

/* rtl/lcd_step_if.sv */
// Purpose: Carries one DAC channel's step request and its result.
// Assumes: Single clock domain.
// Notes: Used between the top and the step units.
`timescale 1ns/1ns
interface lcd_step_if;
   logic load;
   logic [7:0] load_val;
   logic step;
   logic [7:0] step_val;
   logic [7:0] limit;
   logic [8:0] code;
   logic over;
   modport ctl (output load, output load_val, output step, output step_val, output limit,
      input code, input over);
   modport unit (input load, input load_val, input step, input step_val, input limit,
      output code, output over);
endinterface : lcd_step_if

/* rtl/lcd_step_unit.sv */
// Purpose: Holds one 9-bit DAC code with bulk load and signed step update.
// Assumes: load and step never arrive together; load wins if they do.
// Notes: over is a one-cycle pulse when a step is refused.
`timescale 1ns/1ns
module lcd_step_unit (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Channel.
   lcd_step_if.unit ch
);
   import lcd_pkg::*;
   logic [8:0] code_q;
   logic over_q;
   logic signed [9:0] sum;
   logic signed [9:0] inc;

   // Sign-extend the low five bits; the top three are ignored.
   assign inc = {{5{ch.step_val[LCD_STEP_W-1]}}, ch.step_val[LCD_STEP_W-1:0]};
   assign sum = $signed({1'b0, code_q}) + inc;

   // The check and the update happen in the same edge, so a refused step never shows.
   always_ff @(posedge clk) begin
      if (reset) begin
         code_q <= 9'h000;
         over_q <= 1'b0;
      end else begin
         over_q <= 1'b0;
         if (ch.load) begin
            code_q <= {ch.load_val, code_q[0]};
         end else if (ch.step) begin
            // Below zero or above the limit both leave the code alone.
            if (sum[9] || (sum[8:1] > ch.limit)) begin
               over_q <= 1'b1;
            end else begin
               code_q <= sum[8:0];
            end
         end
      end
   end

   assign ch.code = code_q;
   assign ch.over = over_q;
endmodule : lcd_step_unit

/* rtl/lcd_fault_sync.sv */
// Purpose: Three-flop synchroniser with agreement filter for one pin.
// Assumes: Input is asynchronous to clk.
// Notes: The value changes only when the second and third stages agree.
`timescale 1ns/1ns
module lcd_fault_sync #(
   parameter logic RST_VAL = 1'b0
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Pin and clean level.
   input wire logic pin,
   output logic level
);
   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic level_q;

   // First stage feeds only the second.
   always_ff @(posedge clk) begin
      if (reset) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
         level_q <= RST_VAL;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end

   assign level = level_q;
endmodule : lcd_fault_sync

/* rtl/lcd_laser_ctrl.sv */
// Purpose: Register file, DAC code control, deemphasis select and eye-safety latch.
// Assumes: A serial front end delivers decoded one-cycle write and read strobes.
// Notes: reset stands for the power-on reset indication.
`timescale 1ns/1ns
module lcd_laser_ctrl (
   // Clock and power-on reset.
   input wire logic clk,
   input wire logic reset,
   // Decoded register access from the serial port.
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [4:0] reg_addr,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   // Disable pin, asynchronous.
   input wire logic disable_pin,
   // Analog comparator flags, asynchronous.
   input wire logic bias_limit_sense_trip,
   input wire logic bias_monitor_out_high,
   input wire logic out_cm_low,
   input wire logic out_low,
   input wire logic bias_low,
   input wire logic no_ac_input,
   // Fault pin, open drain.
   output logic fault_o,
   output logic fault_oe,
   // Analog settings.
   output logic [8:0] bias_dac,
   output logic [8:0] mod_dac,
   output logic [5:0] deemph_amt,
   output logic eq_on,
   output logic [1:0] eq_profile,
   output logic polarity_normal,
   output logic [7:0] pulse_width,
   output logic laser_on
);
   import lcd_pkg::*;

   lcd_step_if bias_ch ();
   lcd_step_if mod_ch ();

   logic [7:0] ctrl_q;
   logic [7:0] bias_limit_q;
   logic [7:0] mod_limit_q;
   logic [7:0] bias_step_q;
   logic [7:0] mod_step_q;
   logic [7:0] pw_q;
   logic [5:0] deemph_level_q;
   logic [2:0] eq_reg_q;
   logic setup_q;
   logic [7:0] stat1_q;
   logic [7:0] stat2_q;
   logic fault_q;
   logic dis_prev_q;
   logic dis_lvl;
   logic dis_toggle;
   logic [5:0] cmp_raw;
   logic [5:0] cmp_lvl;
   logic hard_now;
   logic soft_now;
   logic wr_free;
   logic wr_ok;
   logic soft_res;
   logic [7:0] rd_d;
   lcd_de_mode_t de_mode;

   // Pins pass the three-stage filter; disable defaults high like an open pin.
   lcd_fault_sync #(.RST_VAL(1'b1)) u_dis_sync (
      .clk(clk),
      .reset(reset),
      .pin(disable_pin),
      .level(dis_lvl)
   );

   assign cmp_raw = {bias_limit_sense_trip, bias_monitor_out_high, out_cm_low, out_low, bias_low, no_ac_input};

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_cmp
         lcd_fault_sync #(.RST_VAL(1'b0)) u_cmp_sync (
            .clk(clk),
            .reset(reset),
            .pin(cmp_raw[gi]),
            .level(cmp_lvl[gi])
         );
      end
   endgenerate

   // Hard faults shut the laser; soft ones only warn.
   assign hard_now = cmp_lvl[5] | cmp_lvl[2] | cmp_lvl[1];
   assign soft_now = cmp_lvl[4] | cmp_lvl[3];
   assign dis_toggle = dis_prev_q ^ dis_lvl;

   // Write gating: setup mode unlocks one following operation.
   assign wr_free = (reg_addr == LCD_ADDR_BIAS_STEP) || (reg_addr == LCD_ADDR_MOD_STEP);
   assign wr_ok = wr_stb && (wr_free || setup_q);
   // Soft reset only takes while the disable pin is high.
   assign soft_res = wr_ok && (reg_addr == LCD_ADDR_CTRL) && wr_data[LCD_CTRL_SOFTRES]
      && dis_lvl;

   // Setup mode arms on the key and falls after the next operation.
   always_ff @(posedge clk) begin
      if (reset) begin
         setup_q <= 1'b0;
      end else if (wr_stb || rd_stb) begin
         setup_q <= wr_stb && (reg_addr == LCD_ADDR_MODE) && (wr_data == LCD_SETUP_KEY)
            && !setup_q;
      end
   end

   // Configuration registers; power-on and soft reset both restore defaults.
   always_ff @(posedge clk) begin
      if (reset || soft_res) begin
         ctrl_q <= LCD_CTRL_RST;
         bias_limit_q <= LCD_ZERO_RST;
         mod_limit_q <= LCD_ZERO_RST;
         pw_q <= LCD_ZERO_RST;
         deemph_level_q <= 6'h00;
         eq_reg_q <= 3'h0;
      end else if (wr_ok) begin
         unique case (reg_addr)
            LCD_ADDR_CTRL: ctrl_q <= wr_data;
            LCD_ADDR_BIAS_LIMIT: bias_limit_q <= wr_data;
            LCD_ADDR_MOD_LIMIT: mod_limit_q <= wr_data;
            LCD_ADDR_PW: pw_q <= wr_data;
            LCD_ADDR_DEEMPH: deemph_level_q <= wr_data[5:0];
            LCD_ADDR_EQ: eq_reg_q <= wr_data[2:0];
            default: ;
         endcase
      end
   end

   // Step registers hold the last written value for readback.
   always_ff @(posedge clk) begin
      if (reset || soft_res) begin
         bias_step_q <= LCD_ZERO_RST;
         mod_step_q <= LCD_ZERO_RST;
      end else if (wr_ok && reg_addr == LCD_ADDR_BIAS_STEP) begin
         bias_step_q <= wr_data;
      end else if (wr_ok && reg_addr == LCD_ADDR_MOD_STEP) begin
         mod_step_q <= wr_data;
      end
   end

   // Bias channel; the step uses the written byte directly so it lands next edge.
   assign bias_ch.load = wr_ok && (reg_addr == LCD_ADDR_BIAS_CODE);
   assign bias_ch.load_val = wr_data;
   assign bias_ch.step = wr_ok && (reg_addr == LCD_ADDR_BIAS_STEP);
   assign bias_ch.step_val = wr_data;
   assign bias_ch.limit = bias_limit_q;
   // Modulation channel.
   assign mod_ch.load = wr_ok && (reg_addr == LCD_ADDR_MOD_CODE);
   assign mod_ch.load_val = wr_data;
   assign mod_ch.step = wr_ok && (reg_addr == LCD_ADDR_MOD_STEP);
   assign mod_ch.step_val = wr_data;
   assign mod_ch.limit = mod_limit_q;

   // Soft reset does not reach the DAC codes; that keeps a restart from stepping the laser.
   lcd_step_unit u_bias (
      .clk(clk),
      .reset(reset),
      .ch(bias_ch.unit)
   );

   lcd_step_unit u_mod (
      .clk(clk),
      .reset(reset),
      .ch(mod_ch.unit)
   );

   // Sticky status; a new event wins over the toggle clear.
   always_ff @(posedge clk) begin
      if (reset) begin
         stat1_q <= LCD_ZERO_RST;
         stat2_q <= LCD_ZERO_RST;
      end else begin
         stat1_q <= (dis_toggle ? LCD_ZERO_RST : stat1_q) |
            {1'b0, cmp_lvl[4], 1'b0, cmp_lvl[5], cmp_lvl[3], cmp_lvl[2], cmp_lvl[1],
             hard_now | soft_now};
         stat2_q <= (dis_toggle ? LCD_ZERO_RST : stat2_q) |
            {4'h0, mod_ch.over, bias_ch.over, cmp_lvl[0], 1'b0};
      end
   end

   // Fault latch; a hard fault present during the toggle keeps it set.
   always_ff @(posedge clk) begin
      if (reset) begin
         fault_q <= 1'b0;
         dis_prev_q <= 1'b1;
      end else begin
         dis_prev_q <= dis_lvl;
         fault_q <= (fault_q && !dis_toggle) || hard_now;
      end
   end

   // Read mux, registered so data comes from flops.
   always_comb begin
      rd_d = LCD_ZERO_RST;
      unique case (reg_addr)
         LCD_ADDR_CTRL: rd_d = {2'b00, ctrl_q[5:0]};
         LCD_ADDR_STAT1: rd_d = stat1_q;
         LCD_ADDR_STAT2: rd_d = stat2_q;
         LCD_ADDR_BIAS_CODE: rd_d = bias_ch.code[8:1];
         LCD_ADDR_MOD_CODE: rd_d = mod_ch.code[8:1];
         LCD_ADDR_MOD_LIMIT: rd_d = mod_limit_q;
         LCD_ADDR_BIAS_LIMIT: rd_d = bias_limit_q;
         LCD_ADDR_MOD_STEP: rd_d = mod_step_q;
         LCD_ADDR_BIAS_STEP: rd_d = bias_step_q;
         LCD_ADDR_MODE: rd_d = {7'h00, setup_q};
         LCD_ADDR_PW: rd_d = pw_q;
         LCD_ADDR_DEEMPH: rd_d = {2'b00, deemph_level_q};
         LCD_ADDR_EQ: rd_d = {5'h00, eq_reg_q};
         default: rd_d = LCD_ZERO_RST;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rd_data <= LCD_ZERO_RST;
      end else if (rd_stb) begin
         rd_data <= rd_d;
      end
   end

   // Deemphasis selection.
   assign de_mode = lcd_de_mode_t'(ctrl_q[LCD_CTRL_DE_HI:LCD_CTRL_DE_LO]);
   always_ff @(posedge clk) begin
      if (reset) begin
         deemph_amt <= 6'h00;
      end else begin
         unique case (de_mode)
            LCD_DE_FIX_6P25: deemph_amt <= LCD_DE_LVL_6P25;
            LCD_DE_FIX_3P125: deemph_amt <= LCD_DE_LVL_3P125;
            LCD_DE_PROG: deemph_amt <= deemph_level_q;
            LCD_DE_MAX: deemph_amt <= LCD_DE_LVL_MAX;
         endcase
      end
   end

   // Output gating: any shutdown cause forces both currents to zero.
   always_ff @(posedge clk) begin
      if (reset) begin
         laser_on <= 1'b0;
         bias_dac <= 9'h000;
         mod_dac <= 9'h000;
         eq_on <= 1'b0;
         eq_profile <= 2'b00;
         polarity_normal <= 1'b1;
         pulse_width <= LCD_ZERO_RST;
      end else begin
         laser_on <= !dis_lvl && ctrl_q[LCD_CTRL_EN] && !fault_q && !hard_now;
         bias_dac <= (!dis_lvl && ctrl_q[LCD_CTRL_EN] && !fault_q && !hard_now)
            ? bias_ch.code : 9'h000;
         // The analog stage subtracts deemph_amt from this code.
         mod_dac <= (!dis_lvl && ctrl_q[LCD_CTRL_EN] && !fault_q && !hard_now)
            ? mod_ch.code : 9'h000;
         eq_on <= ctrl_q[LCD_CTRL_EQ_EN];
         eq_profile <= ctrl_q[LCD_CTRL_EQ_EN] ? eq_reg_q[2:1] : 2'b00;
         polarity_normal <= ctrl_q[LCD_CTRL_POL];
         pulse_width <= pw_q;
      end
   end

   // Open drain: pull low when no fault; release to let the pull-up show a fault.
   assign fault_o = 1'b0;
   assign fault_oe = !fault_q;
endmodule : lcd_laser_ctrl

/* verification/lcd_props.sv */
// Purpose: Port checks for the laser current control block.
// Assumes: One clock; reset synchronous, active high.
// Notes: Pin filters take about four edges, so windows carry margin.
`timescale 1ns/1ns
module lcd_props (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Watched ports.
   input wire logic wr_stb,
   input wire logic disable_pin,
   input wire logic bias_limit_sense_trip,
   input wire logic out_low,
   input wire logic bias_low,
   input wire logic fault_oe,
   input wire logic [8:0] bias_dac,
   input wire logic [8:0] mod_dac,
   input wire logic polarity_normal,
   input wire logic laser_on
);
   logic dis_last_q;
   logic [3:0] dis_age_q;
   logic [3:0] hard_age_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Edges since the disable pin moved; saturates so it never wraps.
   always_ff @(posedge clk) begin
      dis_last_q <= disable_pin;
      if (reset) dis_age_q <= 4'hF;
      else if (disable_pin != dis_last_q) dis_age_q <= 4'h0;
      else if (dis_age_q != 4'hF) dis_age_q <= dis_age_q + 4'h1;
   end
   // Edges since any hard-fault input was last seen high.
   always_ff @(posedge clk) begin
      if (reset) hard_age_q <= 4'hF;
      else if (bias_limit_sense_trip || out_low || bias_low) hard_age_q <= 4'h0;
      else if (hard_age_q != 4'hF) hard_age_q <= hard_age_q + 4'h1;
   end
   sequence quiet_s;
      (laser_on && !wr_stb) [*6];
   endsequence
   sequence trip_s;
      bias_limit_sense_trip [*8];
   endsequence
   a_quiet_dac: assert property (quiet_s |-> $stable(bias_dac) && $stable(mod_dac))
      else $error("DAC code moved without a write");
   a_bias_limit_sense_fault: assert property (trip_s |-> !fault_oe && !laser_on)
      else $error("Comparator trip did not latch a fault");
   a_fault_off: assert property (!fault_oe [*2] |-> !laser_on)
      else $error("Laser on while fault latched");
   a_off_zero: assert property (!laser_on [*2] |-> bias_dac == 9'h000 && mod_dac == 9'h000)
      else $error("DAC nonzero while laser off");
   a_disable_off: assert property (disable_pin [*8] |-> !laser_on)
      else $error("Laser on while disabled");
   a_fault_held: assert property ($rose(fault_oe) |-> dis_age_q < 4'h8)
      else $error("Fault cleared without disable toggle");
   a_soft_warn: assert property ($fell(fault_oe) |-> hard_age_q < 4'h8)
      else $error("Fault latched with no hard cause");
   a_reset_vals: assert property ($past(reset) |-> fault_oe && polarity_normal && !laser_on
      && bias_dac == 9'h000)
      else $error("Outputs not at defaults after reset");
endmodule : lcd_props

/* verification/lcd_host_model.sv */
// Purpose: Host side of the decoded register port.
// Assumes: One strobe per operation, with an idle edge between operations.
// Notes: Released lines are inverted so stale values cannot pass.
`timescale 1ns/1ns
module lcd_host_model (
   // Clock.
   input wire logic clk,
   // Register access.
   output logic wr_stb,
   output logic rd_stb,
   output logic [4:0] reg_addr,
   output logic [7:0] wr_data,
   input wire logic [7:0] rd_data
);
   import lcd_pkg::*;
   // Port idle at time zero.
   initial begin
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      reg_addr = 5'h00;
      wr_data = 8'h00;
   end
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_stb <= 1'b1;
      reg_addr <= a;
      wr_data <= d;
      @(posedge clk);
      wr_stb <= 1'b0;
      reg_addr <= ~a;
      wr_data <= ~d;
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge clk);
      rd_stb <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      rd_stb <= 1'b0;
      reg_addr <= ~a;
      repeat (2) @(posedge clk);
      #1;
      d = rd_data;
   endtask : rd
   // The unlock only covers the very next operation, so it is sent each time.
   task automatic swr(input logic [4:0] a, input logic [7:0] d);
      wr(LCD_ADDR_MODE, LCD_SETUP_KEY);
      wr(a, d);
   endtask : swr
endmodule : lcd_host_model

/* verification/tb.sv */
// Purpose: Self-checking bench for the laser current control block.
// Assumes: Host model drives the register port.
// Notes: Every comparator input is driven by the bench, so each fault path is reached.
`timescale 1ns/1ns
module tb;
   import lcd_pkg::*;
   logic clk, reset, disable_pin, bias_limit_sense_trip, bias_monitor_out_high, be, me, ov;
   logic out_cm_low, out_low, bias_low, no_ac_input;
   logic wr_stb, rd_stb, fault_o, fault_oe, eq_on, polarity_normal, laser_on;
   logic [4:0] reg_addr;
   logic [7:0] wr_data, rd_data, pulse_width, rv, d;
   logic [8:0] bias_dac, mod_dac, bc, mc;
   logic [5:0] deemph_amt;
   logic [1:0] eq_profile;
   int n_errors, n_compared, cyc;
   logic [7:0] corner [6] = '{8'hEF, 8'h0F, 8'h10, 8'h1F, 8'h05, 8'hF0};
   wire fault_wire = fault_oe ? 1'b0 : 1'b1;
   lcd_host_model host (.clk(clk), .wr_stb(wr_stb), .rd_stb(rd_stb), .reg_addr(reg_addr),
      .wr_data(wr_data), .rd_data(rd_data));
   lcd_laser_ctrl dut (.clk(clk), .reset(reset), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .reg_addr(reg_addr), .wr_data(wr_data), .rd_data(rd_data), .disable_pin(disable_pin),
      .bias_limit_sense_trip(bias_limit_sense_trip), .bias_monitor_out_high(bias_monitor_out_high), .out_cm_low(out_cm_low),
      .out_low(out_low), .bias_low(bias_low), .no_ac_input(no_ac_input),
      .fault_o(fault_o), .fault_oe(fault_oe),
      .bias_dac(bias_dac), .mod_dac(mod_dac), .deemph_amt(deemph_amt), .eq_on(eq_on),
      .eq_profile(eq_profile), .polarity_normal(polarity_normal),
      .pulse_width(pulse_width), .laser_on(laser_on));
   // Clock.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // A hung run is cut short and counted as a mismatch.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         summarize();
      end
   end
   task automatic summarize;
      $display("errors=%0d compared=%0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : summarize
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // Next code after a step; a negative or over-limit result keeps the old code.
   function automatic logic [8:0] nxt(input logic [8:0] c, input logic [7:0] s,
      input logic [7:0] lim, output logic o);
      logic [10:0] r;
      r = {2'b00, c} + {{6{s[4]}}, s[4:0]};
      o = r[10] || r[9] || (r[8:1] > lim);
      return o ? c : r[8:0];
   endfunction : nxt
   function automatic logic [5:0] de_exp(input logic [1:0] m);
      return m == 2'b10 ? 6'h25 : m == 2'b00 ? LCD_DE_LVL_6P25 :
         m == 2'b01 ? LCD_DE_LVL_3P125 : LCD_DE_LVL_MAX;
   endfunction : de_exp
   task automatic rst_chk;
      @(posedge clk);
      reset <= 1'b1;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      host.rd(LCD_ADDR_CTRL, rv);
      chk(9'(rv & 8'h3F), 9'(LCD_CTRL_RST));
      host.rd(LCD_ADDR_BIAS_LIMIT, rv);
      chk(9'(rv), 9'(LCD_ZERO_RST));
      host.rd(LCD_ADDR_BIAS_CODE, rv);
      chk(9'(rv), 9'h000);
      host.rd(5'h1F, rv);
      chk(9'(rv), 9'h000);
   endtask : rst_chk
   // Main sequence.
   initial begin
      void'($urandom(32'h91E6));
      reset = 1'b1;
      disable_pin = 1'b0;
      bias_limit_sense_trip = 1'b0;
      bias_monitor_out_high = 1'b0;
      out_cm_low = 1'b0;
      out_low = 1'b0;
      bias_low = 1'b0;
      no_ac_input = 1'b0;
      rst_chk();
      host.swr(LCD_ADDR_BIAS_LIMIT, 8'h40);
      host.swr(LCD_ADDR_MOD_LIMIT, 8'h20);
      host.swr(LCD_ADDR_BIAS_CODE, 8'h3C);
      host.swr(LCD_ADDR_MOD_CODE, 8'h1E);
      host.wr(LCD_ADDR_BIAS_LIMIT, 8'hFF);
      host.rd(LCD_ADDR_BIAS_LIMIT, rv);
      chk(9'(rv), 9'h040);
      bc = 9'h078;
      mc = 9'h03C;
      be = 1'b0;
      me = 1'b0;
      // Corners first: both limits hit, extremes of the step, junk in the top bits.
      for (int i = 0; i < 30; i++) begin
         d = (i < 6) ? corner[i] : 8'($urandom);
         if (i % 2 == 1) begin
            host.wr(LCD_ADDR_MOD_STEP, d);
            mc = nxt(mc, d, 8'h20, ov);
            me = me | ov;
         end else begin
            host.wr(LCD_ADDR_BIAS_STEP, d);
            bc = nxt(bc, d, 8'h40, ov);
            be = be | ov;
         end
         repeat (3) @(posedge clk);
         #1;
         chk(bias_dac, bc);
         chk(mod_dac, mc);
      end
      host.rd(LCD_ADDR_BIAS_CODE, rv);
      chk(9'(rv), 9'(bc[8:1]));
      host.rd(LCD_ADDR_STAT2, rv);
      chk(9'(rv & 8'h0C), 9'({me, be, 2'b00}));
      for (int m = 0; m < 4; m++) begin
         // Polarity follows the upper half of the loop so both levels are seen.
         host.swr(LCD_ADDR_CTRL, 8'(m * 16 + (m % 2) * 8 + (m / 2) * 2 + 1));
         host.swr(LCD_ADDR_DEEMPH, 8'h25);
         host.swr(LCD_ADDR_EQ, 8'(m * 2));
         d = 8'($urandom);
         host.swr(LCD_ADDR_PW, d);
         repeat (3) @(posedge clk);
         #1;
         chk(9'(deemph_amt), 9'(de_exp(2'(m))));
         chk(9'(polarity_normal), 9'(m / 2));
         chk(9'(pulse_width), 9'(d));
         chk(9'(eq_on), 9'(m % 2));
         if (m % 2 == 1) chk(9'(eq_profile), 9'(m));
      end
      host.swr(LCD_ADDR_CTRL, 8'h02);
      repeat (4) @(posedge clk);
      #1;
      chk(9'(laser_on) | bias_dac, 9'h000);
      host.swr(LCD_ADDR_CTRL, LCD_CTRL_RST);
      @(posedge clk);
      bias_monitor_out_high <= 1'b1;
      out_cm_low <= 1'b1;
      no_ac_input <= 1'b1;
      repeat (10) @(posedge clk);
      bias_monitor_out_high <= 1'b0;
      out_cm_low <= 1'b0;
      no_ac_input <= 1'b0;
      #1;
      chk(9'({fault_wire, laser_on}), 9'h001);
      host.rd(LCD_ADDR_STAT1, rv);
      chk(9'(rv & 8'h49), 9'h049);
      host.rd(LCD_ADDR_STAT2, rv);
      chk(9'(rv & 8'h02), 9'h002);
      @(posedge clk);
      bias_limit_sense_trip <= 1'b1;
      repeat (10) @(posedge clk);
      bias_limit_sense_trip <= 1'b0;
      repeat (10) @(posedge clk);
      #1;
      chk(9'({fault_o, fault_wire}), 9'h001);
      chk(bias_dac | mod_dac, 9'h000);
      host.rd(LCD_ADDR_STAT1, rv);
      chk(9'(rv & 8'h59), 9'h059);
      @(posedge clk);
      disable_pin <= 1'b1;
      repeat (10) @(posedge clk);
      disable_pin <= 1'b0;
      repeat (10) @(posedge clk);
      #1;
      chk(9'(fault_wire), 9'h000);
      chk(bias_dac, bc);
      host.rd(LCD_ADDR_STAT1, rv);
      chk(9'(rv & 8'h5F), 9'h000);
      host.rd(LCD_ADDR_STAT2, rv);
      chk(9'(rv & 8'h0E), 9'h000);
      // Each remaining hard cause latches the fault alone; a toggle clears it again.
      for (int k = 1; k < 3; k++) begin
         @(posedge clk);
         bias_low <= (k == 1);
         out_low <= (k == 2);
         repeat (10) @(posedge clk);
         bias_low <= 1'b0;
         out_low <= 1'b0;
         repeat (10) @(posedge clk);
         #1;
         chk(9'({fault_wire, laser_on}), 9'h002);
         host.rd(LCD_ADDR_STAT1, rv);
         chk(9'(rv & 8'h07), 9'((1 << k) | 1));
         @(posedge clk);
         disable_pin <= 1'b1;
         repeat (10) @(posedge clk);
         disable_pin <= 1'b0;
         repeat (10) @(posedge clk);
         #1;
         chk(9'(fault_wire), 9'h000);
      end
      // Soft reset takes only with disable high; limits fall back while codes stay.
      @(posedge clk);
      disable_pin <= 1'b1;
      repeat (6) @(posedge clk);
      host.swr(LCD_ADDR_CTRL, 8'h07);
      disable_pin <= 1'b0;
      repeat (6) @(posedge clk);
      host.rd(LCD_ADDR_BIAS_LIMIT, rv);
      chk(9'(rv), 9'(LCD_ZERO_RST));
      host.rd(LCD_ADDR_CTRL, rv);
      chk(9'(rv), 9'(LCD_CTRL_RST));
      host.rd(LCD_ADDR_BIAS_CODE, rv);
      chk(9'(rv), 9'(bc[8:1]));
      rst_chk();
      summarize();
   end
endmodule : tb
bind lcd_laser_ctrl lcd_props u_props (.clk(clk), .reset(reset), .wr_stb(wr_stb),
   .disable_pin(disable_pin), .bias_limit_sense_trip(bias_limit_sense_trip), .out_low(out_low), .bias_low(bias_low),
   .fault_oe(fault_oe), .bias_dac(bias_dac), .mod_dac(mod_dac),
   .polarity_normal(polarity_normal), .laser_on(laser_on));
